// >>> rtl/adc_seq_pkg.sv
package adc_seq_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;
    localparam int RESULT_W = 12;
    localparam int CHAN_W = 5;

    // byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GUARD_LOW = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_GUARD_HIGH = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h4C;

    // reset values
    localparam logic [BUS_W-1:0] RST_CONTROL_ONE = 32'h0000_0000;
    localparam logic [BUS_W-1:0] RST_CONTROL_TWO = 32'h0000_0000;
    localparam logic [2:0] RST_STATUS = 3'h0;
    localparam logic [RESULT_W-1:0] RST_GUARD_LOW = 12'h000;
    localparam logic [RESULT_W-1:0] RST_GUARD_HIGH = 12'hFFF;
    localparam logic [RESULT_W-1:0] RST_DATA = 12'h000;

    // writable bits; everything else reads zero
    localparam logic [BUS_W-1:0] CONTROL_ONE_MASK = 32'h00CF_FFFF;
    localparam logic [BUS_W-1:0] CONTROL_ONE_SEC_MASK = 32'h00C0_FFFF;
    localparam logic [BUS_W-1:0] CONTROL_TWO_MASK = 32'h00FE_F90F;

    // control one field positions
    localparam int POS_REGULAR_GUARD_ENABLE = 23;
    localparam int POS_INJECTED_GUARD_ENABLE = 22;
    localparam int POS_PAIR_MODE_LO = 16;
    localparam int POS_SPLIT_COUNT_LO = 13;
    localparam int POS_INJECTED_SPLIT_ENABLE = 12;
    localparam int POS_REGULAR_SPLIT_ENABLE = 11;
    localparam int POS_AUTO_INJECTED = 10;
    localparam int POS_GUARD_SINGLE_CHANNEL = 9;
    localparam int POS_SCAN_ENABLE = 8;
    localparam int POS_INJECTED_DONE_IRQ_ENABLE = 7;
    localparam int POS_GUARD_IRQ_ENABLE = 6;
    localparam int POS_CONV_DONE_IRQ_ENABLE = 5;
    localparam int POS_GUARD_CHANNEL_LO = 0;

    // status flag positions
    localparam int POS_GUARD_EVENT_FLAG = 0;
    localparam int POS_CONV_DONE_FLAG = 1;
    localparam int POS_INJECTED_DONE_FLAG = 2;

    // pair mode codes
    localparam logic [3:0] PAIR_INDEPENDENT = 4'h0;
    localparam logic [3:0] PAIR_REG_SIM_INJ_SIM = 4'h1;
    localparam logic [3:0] PAIR_REG_SIM_ALT_TRIG = 4'h2;
    localparam logic [3:0] PAIR_INJ_SIM_FAST_IL = 4'h3;
    localparam logic [3:0] PAIR_INJ_SIM_SLOW_IL = 4'h4;
    localparam logic [3:0] PAIR_INJ_SIM_ONLY = 4'h5;
    localparam logic [3:0] PAIR_REG_SIM_ONLY = 4'h6;
    localparam logic [3:0] PAIR_FAST_IL_ONLY = 4'h7;
    localparam logic [3:0] PAIR_SLOW_IL_ONLY = 4'h8;
    localparam logic [3:0] PAIR_ALT_TRIG_ONLY = 4'h9;

    localparam logic [CHAN_W-1:0] GUARD_CHANNEL_MAX = 5'h11;

    typedef struct packed {
        logic done;
        logic injected;
        logic last;
        logic [CHAN_W-1:0] channel;
        logic [RESULT_W-1:0] value;
    } conv_result_t;

    typedef struct packed {
        logic [3:0] pair_mode;
        logic regular_split_enable;
        logic injected_split_enable;
        logic [3:0] split_channel_count;
        logic auto_injected_after_regular;
        logic scan_enable;
    } seq_cfg_t;

    typedef struct packed {
        logic regular_guard_enable;
        logic injected_guard_enable;
        logic guard_single_channel;
        logic [CHAN_W-1:0] guard_channel_select;
        logic [RESULT_W-1:0] low;
        logic [RESULT_W-1:0] high;
    } guard_cfg_t;

endpackage

// >>> rtl/guard_check.sv
module guard_check (
    // conversion under test
    input wire adc_seq_pkg::conv_result_t result,
    // guard settings
    input wire adc_seq_pkg::guard_cfg_t cfg,
    // outcome
    output logic hit
);
    import adc_seq_pkg::*;

    logic group_on;
    logic channel_on;
    logic outside;

    always_comb begin
        group_on = result.injected ? cfg.injected_guard_enable // (RULE2)
                                   : cfg.regular_guard_enable; // (RULE1)
        // reserved channel codes never match a real channel
        channel_on = !cfg.guard_single_channel
                     || (result.channel == cfg.guard_channel_select
                         && cfg.guard_channel_select <= GUARD_CHANNEL_MAX); // (RULE10) (RULE17)
        outside = (result.value < cfg.low) || (result.value > cfg.high); // (RULE21)
        hit = result.done && group_on && channel_on && outside;
    end

endmodule

// >>> rtl/adc_sequencer_control_regs.sv
// Summary of operation
// (RULE1) regular watchdog enable bit 23 checks regulars
// (RULE2) injected watchdog enable bit 22 checks injected
// (RULE3) bits 19:16 select pair operating mode
// (RULE4) pair mode exists only in master instance
// (RULE5) software disables pair mode before reconfiguring
// (RULE6) split count field 15:13 gives value plus one
// (RULE7) bit 12 enables injected group splitting
// (RULE8) bit 11 enables regular group splitting
// (RULE9) bit 10 starts injected after regular completes
// (RULE10) bit 9 guards single selected channel only
// (RULE11) bit 8 enables scan of sequence lists
// (RULE12) scan raises done only after last channel
// (RULE13) bit 7 enables injected done interrupt
// (RULE14) bit 6 enables watchdog interrupt
// (RULE15) scan aborted on crossing only if bit 6
// (RULE16) bit 5 enables conversion done interrupt
// (RULE17) bits 4:0 pick guarded channel 0..17
// (RULE18) software writes zero to reserved bits
// (RULE19) done flag set on group end, cleared twice
// (RULE20) injected done flag set after whole group
// (RULE21) watchdog flag set outside thresholds
// (RULE22) interrupt high while enabled flag set
// (RULE23) reserved control bits ignore writes, read zero
//
// The Avalon-MM slave port was chosen for this implementation.
module adc_sequencer_control_regs #(
    parameter bit IS_MASTER = 1'b1,
    parameter int CHANNELS = 18
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [adc_seq_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [adc_seq_pkg::BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [adc_seq_pkg::BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // converter sequencer
    input wire adc_seq_pkg::conv_result_t conv_result,
    output adc_seq_pkg::seq_cfg_t seq_cfg,
    output logic [adc_seq_pkg::BUS_W-1:0] control_two_bits,
    output logic scan_abort,
    output logic injected_auto_start,
    // interrupt
    output logic irq
);
    import adc_seq_pkg::*;

    if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
        $error("CHANNELS must lie between 1 and 32");
    end

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

    function automatic logic [BUS_W-1:0] lane_mask(input logic [3:0] be);
        logic [BUS_W-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    function automatic logic [BUS_W-1:0] merge(input logic [BUS_W-1:0] old_val,
                                               input logic [BUS_W-1:0] new_val,
                                               input logic [3:0] be,
                                               input logic [BUS_W-1:0] keep);
        logic [BUS_W-1:0] m;
        m = lane_mask(be);
        return ((old_val & ~m) | (new_val & m)) & keep;
    endfunction

    // the first stage is read only by the second
    logic [1:0] rst_sync_reg;
    logic rst_core_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_core_n = rst_sync_reg[1];

    // secondaries hide pair mode
    localparam logic [BUS_W-1:0] ONE_KEEP = IS_MASTER ? CONTROL_ONE_MASK
                                                      : CONTROL_ONE_SEC_MASK; // (RULE4) (RULE23)

    bus_state_t bus_state_reg, bus_state_next;
    logic [BUS_W-1:0] readdata_reg, readdata_next;
    logic [BUS_W-1:0] control_one_reg, control_one_next;
    logic [BUS_W-1:0] control_two_reg, control_two_next;
    logic [2:0] status_reg, status_next;
    logic [RESULT_W-1:0] guard_low_reg, guard_low_next;
    logic [RESULT_W-1:0] guard_high_reg, guard_high_next;
    logic [RESULT_W-1:0] data_reg, data_next;
    logic scan_abort_reg, scan_abort_next;
    logic auto_start_reg, auto_start_next;

    logic request;
    logic take;
    logic take_write;
    logic take_read;
    logic [ADDR_W-1:0] word_addr;
    logic [2:0] flag_set;
    logic [2:0] flag_clear;
    logic [2:0] flag_enable;
    logic guard_hit;
    logic group_end;
    guard_cfg_t guard_cfg;

    assign request = avs_read || avs_write;
    assign word_addr = {avs_address[ADDR_W-1:2], 2'b00};
    // one wait cycle, then the request is taken
    assign take = request && (bus_state_reg == BUS_ANSWER);
    assign take_write = take && avs_write;
    assign take_read = take && avs_read;
    assign avs_waitrequest = request && (bus_state_reg != BUS_ANSWER);
    assign avs_readdata = readdata_reg;

    always_comb begin
        guard_cfg.regular_guard_enable = control_one_reg[POS_REGULAR_GUARD_ENABLE]; // (RULE1)
        guard_cfg.injected_guard_enable = control_one_reg[POS_INJECTED_GUARD_ENABLE]; // (RULE2)
        guard_cfg.guard_single_channel = control_one_reg[POS_GUARD_SINGLE_CHANNEL]; // (RULE10)
        guard_cfg.guard_channel_select =
            control_one_reg[POS_GUARD_CHANNEL_LO +: CHAN_W]; // (RULE17)
        guard_cfg.low = guard_low_reg;
        guard_cfg.high = guard_high_reg;
    end

    guard_check u_guard_check (
        .result(conv_result),
        .cfg(guard_cfg),
        .hit(guard_hit)
    );

    // bus state and read data
    always_comb begin
        bus_state_next = bus_state_reg;
        readdata_next = readdata_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (request) begin
                    bus_state_next = BUS_ANSWER;
                    readdata_next = '0;
                    if (avs_read) begin
                        case (word_addr)
                            OFS_STATUS: readdata_next = {29'h0, status_reg};
                            OFS_CONTROL_ONE: readdata_next = control_one_reg; // (RULE23)
                            OFS_CONTROL_TWO: readdata_next = control_two_reg; // (RULE23)
                            OFS_GUARD_LOW: readdata_next = {20'h0, guard_low_reg};
                            OFS_GUARD_HIGH: readdata_next = {20'h0, guard_high_reg};
                            OFS_DATA: readdata_next = {20'h0, data_reg};
                            default: readdata_next = '0;
                        endcase
                    end
                end
            end
            BUS_ANSWER: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            bus_state_reg <= BUS_IDLE;
            readdata_reg <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            readdata_reg <= readdata_next;
        end
    end

    // control and threshold registers
    always_comb begin
        control_one_next = control_one_reg;
        control_two_next = control_two_reg;
        guard_low_next = guard_low_reg;
        guard_high_next = guard_high_reg;
        if (take_write) begin
            case (word_addr)
                OFS_CONTROL_ONE: begin
                    control_one_next = merge(control_one_reg, avs_writedata,
                                             avs_byteenable, ONE_KEEP); // (RULE23)
                end
                OFS_CONTROL_TWO: begin
                    control_two_next = merge(control_two_reg, avs_writedata,
                                             avs_byteenable, CONTROL_TWO_MASK); // (RULE23)
                end
                OFS_GUARD_LOW: begin
                    guard_low_next = RESULT_W'(merge({20'h0, guard_low_reg}, avs_writedata,
                                                     avs_byteenable, 32'h0000_0FFF));
                end
                OFS_GUARD_HIGH: begin
                    guard_high_next = RESULT_W'(merge({20'h0, guard_high_reg}, avs_writedata,
                                                      avs_byteenable, 32'h0000_0FFF));
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            control_one_reg <= RST_CONTROL_ONE;
            control_two_reg <= RST_CONTROL_TWO;
            guard_low_reg <= RST_GUARD_LOW;
            guard_high_reg <= RST_GUARD_HIGH;
        end else begin
            control_one_reg <= control_one_next;
            control_two_reg <= control_two_next;
            guard_low_reg <= guard_low_next;
            guard_high_reg <= guard_high_next;
        end
    end

    // status flags, data and sequencer pulses
    always_comb begin
        // without scan every conversion is a whole group
        group_end = conv_result.done
                    && (!control_one_reg[POS_SCAN_ENABLE] || conv_result.last); // (RULE12)
        flag_set = '0;
        flag_set[POS_CONV_DONE_FLAG] = group_end; // (RULE19)
        flag_set[POS_INJECTED_DONE_FLAG] = group_end && conv_result.injected; // (RULE20)
        flag_set[POS_GUARD_EVENT_FLAG] = guard_hit; // (RULE21)

        // write zero clears, one keeps
        flag_clear = '0;
        if (take_write && word_addr == OFS_STATUS && avs_byteenable[0]) begin
            flag_clear = ~avs_writedata[2:0];
        end
        if (take_read && word_addr == OFS_DATA) begin
            flag_clear[POS_CONV_DONE_FLAG] = 1'b1; // (RULE19)
        end
        // a flag set in the clearing cycle survives
        status_next = (status_reg & ~flag_clear) | flag_set;

        data_next = conv_result.done ? conv_result.value : data_reg;

        // only an enabled guard irq stops a scan
        scan_abort_next = guard_hit && control_one_reg[POS_SCAN_ENABLE]
                          && control_one_reg[POS_GUARD_IRQ_ENABLE]; // (RULE15)
        auto_start_next = group_end && !conv_result.injected
                          && control_one_reg[POS_AUTO_INJECTED]; // (RULE9)
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            status_reg <= RST_STATUS;
            data_reg <= RST_DATA;
            scan_abort_reg <= 1'b0;
            auto_start_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            data_reg <= data_next;
            scan_abort_reg <= scan_abort_next;
            auto_start_reg <= auto_start_next;
        end
    end

    assign scan_abort = scan_abort_reg;
    assign injected_auto_start = auto_start_reg;

    always_comb begin
        flag_enable = '0;
        flag_enable[POS_CONV_DONE_FLAG] = control_one_reg[POS_CONV_DONE_IRQ_ENABLE]; // (RULE16)
        flag_enable[POS_INJECTED_DONE_FLAG] =
            control_one_reg[POS_INJECTED_DONE_IRQ_ENABLE]; // (RULE13)
        flag_enable[POS_GUARD_EVENT_FLAG] = control_one_reg[POS_GUARD_IRQ_ENABLE]; // (RULE14)
    end

    // level, drops once no enabled flag is set
    assign irq = |(status_reg & flag_enable); // (RULE22)

    // configuration handed to the sequencer
    always_comb begin
        // undefined codes act as independent
        if (control_one_reg[POS_PAIR_MODE_LO +: 4] > PAIR_ALT_TRIG_ONLY) begin
            seq_cfg.pair_mode = PAIR_INDEPENDENT;
        end else begin
            seq_cfg.pair_mode = control_one_reg[POS_PAIR_MODE_LO +: 4]; // (RULE3) (RULE4)
        end
        seq_cfg.regular_split_enable = control_one_reg[POS_REGULAR_SPLIT_ENABLE]; // (RULE8)
        seq_cfg.injected_split_enable = control_one_reg[POS_INJECTED_SPLIT_ENABLE]; // (RULE7)
        seq_cfg.split_channel_count =
            {1'b0, control_one_reg[POS_SPLIT_COUNT_LO +: 3]} + 4'h1; // (RULE6)
        seq_cfg.auto_injected_after_regular = control_one_reg[POS_AUTO_INJECTED]; // (RULE9)
        seq_cfg.scan_enable = control_one_reg[POS_SCAN_ENABLE]; // (RULE11)
    end

    assign control_two_bits = control_two_reg;

endmodule

// >>> verification/adc_sequencer_control_regs_sva.sv
module adc_sequencer_control_regs_sva #(
    parameter bit IS_MASTER = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [adc_seq_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [adc_seq_pkg::BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [adc_seq_pkg::BUS_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire adc_seq_pkg::conv_result_t conv_result,
    input wire adc_seq_pkg::seq_cfg_t seq_cfg,
    input wire logic scan_abort,
    input wire logic injected_auto_start,
    input wire logic irq
);
    import adc_seq_pkg::*;
    logic [BUS_W-1:0] shadow_reg, shadow_next, mask;
    logic auto_ev, ab_ev, ev, take_wr, grp_end, rd_one;
    assign mask = IS_MASTER ? CONTROL_ONE_MASK : CONTROL_ONE_SEC_MASK;
    // control one modelled from bus traffic alone
    always_comb begin
        take_wr = avs_write && !avs_waitrequest;
        rd_one = avs_read && !avs_waitrequest && avs_address[7:2] == OFS_CONTROL_ONE[7:2];
        grp_end = conv_result.done && (!shadow_reg[8] || conv_result.last);
        shadow_next = shadow_reg;
        if (take_wr && avs_address[7:2] == OFS_CONTROL_ONE[7:2]) begin
            for (int i = 0; i < 4; i++) begin
                if (avs_byteenable[i]) begin
                    shadow_next[8*i +: 8] = avs_writedata[8*i +: 8] & mask[8*i +: 8];
                end
            end
        end
        auto_ev = grp_end && !conv_result.injected && shadow_reg[10];
        ab_ev = conv_result.done && shadow_reg[8] && shadow_reg[POS_GUARD_IRQ_ENABLE];
        ev = conv_result.done || take_wr;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_reg <= 32'h0;
        end else begin
            shadow_reg <= shadow_next;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_wait_bound;
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("request not answered");
    property p_wait_once;
        (avs_read || avs_write) && !avs_waitrequest
            |=> !(avs_read || avs_write) || avs_waitrequest;
    endproperty
    a_wait_once: assert property (p_wait_once) else $error("second request not held off");
    property p_readback;
        rd_one |-> avs_readdata == shadow_reg;
    endproperty
    a_readback: assert property (p_readback) else $error("control one readback wrong");
    property p_two_reserved;
        avs_read && !avs_waitrequest && avs_address[7:2] == OFS_CONTROL_TWO[7:2]
            |-> (avs_readdata & ~CONTROL_TWO_MASK) == 32'h0;
    endproperty
    a_two_reserved: assert property (p_two_reserved) else $error("control two reserved");
    property p_decode;
        seq_cfg.scan_enable == shadow_reg[8]
            && seq_cfg.auto_injected_after_regular == shadow_reg[10]
            && seq_cfg.regular_split_enable == shadow_reg[11]
            && seq_cfg.injected_split_enable == shadow_reg[12]
            && seq_cfg.split_channel_count == {1'b0, shadow_reg[15:13]} + 4'h1;
    endproperty
    a_decode: assert property (p_decode) else $error("decode");
    property p_pair;
        seq_cfg.pair_mode == ((IS_MASTER && shadow_reg[19:16] <= 4'h9) ? shadow_reg[19:16] : 4'h0);
    endproperty
    a_pair: assert property (p_pair) else $error("pair mode decode wrong");
    property p_auto;
        injected_auto_start == $past(auto_ev);
    endproperty
    a_auto: assert property (p_auto) else $error("auto injected start wrong");
    property p_abort;
        scan_abort |-> $past(ab_ev);
    endproperty
    a_abort: assert property (p_abort) else $error("scan abort without cause");
    property p_irq_off;
        !(shadow_reg[7] || shadow_reg[6] || shadow_reg[5]) |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("stray irq");
    property p_irq_rise;
        $rose(irq) |-> $past(ev);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without event");
endmodule

// >>> verification/adc_sequencer_control_regs_tb.sv
module adc_sequencer_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = 8'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [BUS_W-1:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [BUS_W-1:0] avs_readdata, sec_readdata, control_two_bits, rd, rd2;
    logic avs_waitrequest, scan_abort, injected_auto_start, irq, ab, au;
    conv_result_t conv_result = '0;
    seq_cfg_t seq_cfg;
    int num_errors = 0;
    int n_tests = 0;
    always #4 core_clk = ~core_clk;
    adc_sequencer_control_regs dut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .conv_result,
        .seq_cfg, .control_two_bits, .scan_abort, .injected_auto_start, .irq);
    // secondary on the same bus; readback judged
    adc_sequencer_control_regs #(.IS_MASTER(1'b0)) dut_sec (.core_clk, .rst_n, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata(sec_readdata),
        .avs_waitrequest(), .conv_result, .seq_cfg(), .control_two_bits(), .scan_abort(),
        .injected_auto_start(), .irq());
    task automatic check_word(input logic [31:0] exp, input logic [31:0] act);
        n_tests++;
        if (act !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    task automatic check_bit(input logic exp, input logic act);
        check_word({31'h0, exp}, {31'h0, act});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // held until waitrequest sampled low
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       input logic [3:0] be);
        @(posedge core_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= addr;
        avs_writedata <= data;
        avs_byteenable <= be;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rd2 = sec_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        #1;
    endtask
    task automatic conv(input logic inj, input logic last, input logic [4:0] ch,
                        input logic [11:0] val);
        @(posedge core_clk);
        conv_result <= {1'b1, inj, last, ch, val};
        @(posedge core_clk);
        conv_result.done <= 1'b0;
        #1;
        ab = scan_abort;
        au = injected_auto_start;
    endtask
    task automatic t_reset();
        bus(0, OFS_CONTROL_ONE, 32'h0, 4'hF);
        check_word(32'h0000_0000, rd);
        bus(0, OFS_CONTROL_TWO, 32'h0, 4'hF);
        check_word(32'h0000_0000, rd);
        check_word(32'h1, {28'h0, seq_cfg.split_channel_count});
        $display("test reset values done");
    endtask
    task automatic t_reserved();
        bus(1, OFS_CONTROL_ONE, 32'hFFFF_FFFF, 4'hF);
        bus(0, OFS_CONTROL_ONE, 32'h0, 4'hF);
        check_word(32'h00CF_FFFF, rd);
        check_word(32'h00C0_FFFF, rd2);
        check_word(32'h0, {28'h0, seq_cfg.pair_mode});
        bus(1, OFS_CONTROL_ONE, 32'h0, 4'h1);
        bus(0, OFS_CONTROL_ONE, 32'h0, 4'hF);
        check_word(32'h00CF_FF00, rd);
        bus(1, OFS_CONTROL_TWO, 32'hFFFF_FFFF, 4'hF);
        bus(0, OFS_CONTROL_TWO, 32'h0, 4'hF);
        check_word(32'h00FE_F90F, rd);
        check_word(32'h00FE_F90F, control_two_bits);
        bus(1, 8'h40, 32'hFFFF_FFFF, 4'hF);
        bus(0, 8'h40, 32'h0, 4'hF);
        check_word(32'h0, rd);
        $display("test reserved bits done");
    endtask
    task automatic t_fields();
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            bus(1, OFS_CONTROL_ONE, {16'h0, k, k[0], ~k[0], k[1], 1'b0, k[2], 8'h00}, 4'hF);
            check_word({28'h0, 1'b0, k} + 32'h1, {28'h0, seq_cfg.split_channel_count});
            check_word({28'h0, k[0], ~k[0], k[1], k[2]}, {28'h0, seq_cfg.injected_split_enable,
                seq_cfg.regular_split_enable, seq_cfg.auto_injected_after_regular,
                seq_cfg.scan_enable});
        end
        for (int p = 0; p < 10; p++) begin
            bus(1, OFS_CONTROL_ONE, {12'h0, p[3:0], 16'h0}, 4'hF);
            check_word({28'h0, p[3:0]}, {28'h0, seq_cfg.pair_mode});
            bus(0, OFS_CONTROL_ONE, 32'h0, 4'hF);
            check_word(32'h0, rd2);
        end
        bus(1, OFS_CONTROL_ONE, 32'h0, 4'hF);
        $display("test field decode done");
    endtask
    task automatic t_done();
        bus(1, OFS_CONTROL_ONE, 32'h0000_0020, 4'hF);
        conv(0, 0, 5'h2, 12'h0AB);
        check_bit(1'b1, irq);
        bus(1, OFS_STATUS, 32'h0, 4'h1);
        check_bit(1'b0, irq);
        bus(1, OFS_CONTROL_ONE, 32'h0000_0120, 4'hF);
        conv(0, 0, 5'h2, 12'hABC);
        check_bit(1'b0, irq);
        conv(0, 1, 5'h3, 12'h123);
        check_bit(1'b1, irq);
        bus(0, OFS_STATUS, 32'h0, 4'hF);
        check_word(32'h2, rd);
        bus(0, OFS_DATA, 32'h0, 4'hF);
        check_word(32'h0000_0123, rd);
        check_bit(1'b0, irq);
        $display("test conversion done flag done");
    endtask
    task automatic t_inj();
        bus(1, OFS_CONTROL_ONE, 32'h0000_0580, 4'hF);
        conv(0, 1, 5'h1, 12'h010);
        check_bit(1'b1, au);
        check_bit(1'b0, irq);
        conv(1, 0, 5'h4, 12'h020);
        check_bit(1'b0, irq);
        conv(1, 1, 5'h5, 12'h030);
        check_bit(1'b1, irq);
        check_bit(1'b0, au);
        bus(0, OFS_STATUS, 32'h0, 4'hF);
        check_word(32'h6, rd);
        bus(1, OFS_STATUS, 32'h0000_0003, 4'h1);
        bus(0, OFS_STATUS, 32'h0, 4'hF);
        check_word(32'h2, rd);
        check_bit(1'b0, irq);
        bus(1, OFS_CONTROL_ONE, 32'h0000_0080, 4'hF);
        conv(0, 1, 5'h1, 12'h010);
        check_bit(1'b0, au);
        $display("test injected group done");
    endtask
    task automatic t_guard();
        bus(1, OFS_STATUS, 32'h0, 4'h1);
        bus(1, OFS_GUARD_LOW, 32'h0000_0100, 4'hF);
        bus(1, OFS_GUARD_HIGH, 32'h0000_0200, 4'hF);
        bus(1, OFS_CONTROL_ONE, 32'h0080_0343, 4'hF);
        conv(0, 1, 5'h5, 12'h300);
        check_bit(1'b0, ab);
        check_bit(1'b0, irq);
        conv(0, 1, 5'h3, 12'h150);
        check_bit(1'b0, irq);
        conv(0, 1, 5'h3, 12'h300);
        check_bit(1'b1, ab);
        check_bit(1'b1, irq);
        bus(1, OFS_STATUS, 32'h0, 4'h1);
        conv(1, 1, 5'h3, 12'h300);
        check_bit(1'b0, irq);
        bus(1, OFS_CONTROL_ONE, 32'h0080_0100, 4'hF);
        conv(0, 0, 5'h9, 12'h050);
        check_bit(1'b0, ab);
        bus(0, OFS_STATUS, 32'h0, 4'hF);
        check_word(32'h7, rd);
        bus(1, OFS_STATUS, 32'h0, 4'h1);
        bus(1, OFS_CONTROL_ONE, 32'h0040_0252, 4'hF);
        conv(1, 1, 5'h12, 12'hFFF);
        check_bit(1'b0, irq);
        $display("test guard done");
    endtask
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_reserved();
        t_fields();
        t_done();
        t_inj();
        t_guard();
        end_of_test();
    end
endmodule
bind adc_sequencer_control_regs adc_sequencer_control_regs_sva #(.IS_MASTER(IS_MASTER)) u_sva (
    .core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .conv_result, .seq_cfg, .scan_abort, .injected_auto_start,
    .irq);
